// ---- design/nsx_alu.sv ----
// Single-cycle execution unit for nibble exchange, xor literal and subtract
//
// Overview of operation
// - Exchange operand nibbles, flags untouched, opcode 001110.
// - Exchange and register subtract: dest bit 0 writes accumulator, 1 writes register.
// - Xor literal into accumulator, update zero only.
// - Zero subtraction result sets carry.
// - Negative subtraction clears carry, result wraps.
`timescale 1ns/1ps
`include "nsx_defines.svh"

module nsx_alu
	import nsx_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Instruction from the decoder
	input  wire logic        instr_valid,
	input  wire logic [13:0] instr_word,
	// Operand read from the register file at the addressed location
	input  wire logic [7:0]  reg_rd_data,
	// Register file write-back
	output logic             reg_wr_en,
	output logic [6:0]       reg_wr_addr,
	output logic [7:0]       reg_wr_data,
	// Architectural state
	output logic [7:0]       acc,
	output logic             zero_flag,
	output logic             carry_flag,
	output logic             digit_carry_flag
);

	////////////////////////////////////////////////////////////////////////////
	// Decoded instruction
	nsx_op_t     op;
	logic [5:0]  opc;
	logic        dest;
	logic [6:0]  rd_addr;
	logic [7:0]  lit;
	logic        is_exchange;
	logic        is_xor_lit;
	logic        is_sub_lit;
	logic        is_sub_reg;
	logic        is_sub;
	logic        to_reg;
	logic        to_acc;

	// Operands and results
	logic        fwd_hit;
	logic [7:0]  operand;
	logic [7:0]  minuend;
	logic [7:0]  diff;
	logic        borrow_n;
	logic        nibble_borrow_n;
	logic [7:0]  result;

	// Architectural state
	logic [7:0]  acc_q;
	logic        zero_q;
	logic        carry_q;
	logic        digit_carry_q;
	logic        wr_en_q;
	logic [6:0]  wr_addr_q;
	logic [7:0]  wr_data_q;

	////////////////////////////////////////////////////////////////////////////
	// Instruction fields
	assign opc     = instr_word[`NSX_OPC_MSB:`NSX_OPC_LSB];
	assign dest    = instr_word[`NSX_DEST_BIT];
	assign rd_addr = instr_word[`NSX_ADDR_MSB:0];
	assign lit     = instr_word[`NSX_LIT_MSB:0];

	// Unknown opcodes fall through to no operation: accumulator and flags hold and no write-back is strobed
	always_comb begin
		op = NSX_OP_NONE;
		if (!instr_valid) begin
			op = NSX_OP_NONE;
		end else if (opc == `NSX_OPC_NIBBLE_EXCHANGE) begin
			op = NSX_OP_NIBBLE_EXCHANGE;
		end else if (opc == `NSX_OPC_XOR_LIT_ACC) begin
			op = NSX_OP_XOR_LITERAL_ACC;
		end else if (opc[5:1] == `NSX_OPC_SUB_LIT_HI) begin
			op = NSX_OP_SUB_ACC_FROM_LITERAL;
		end else if (opc == `NSX_OPC_SUB_ACC_REG) begin
			op = NSX_OP_SUB_ACC_FROM_REG;
		end
	end

	assign is_exchange = (op == NSX_OP_NIBBLE_EXCHANGE);
	assign is_xor_lit  = (op == NSX_OP_XOR_LITERAL_ACC);
	assign is_sub_lit  = (op == NSX_OP_SUB_ACC_FROM_LITERAL);
	assign is_sub_reg  = (op == NSX_OP_SUB_ACC_FROM_REG);
	assign is_sub      = is_sub_lit || is_sub_reg;

	// Literal forms always land in the accumulator; register forms follow dest
	assign to_reg = (is_exchange || is_sub_reg) && dest;
	assign to_acc = is_xor_lit || is_sub_lit || ((is_exchange || is_sub_reg) && !dest);

	////////////////////////////////////////////////////////////////////////////
	// The register file commits a write one edge after the strobe, so an
	// instruction right behind a write-back would read a stale operand
	assign fwd_hit = wr_en_q && (wr_addr_q == rd_addr);
	assign operand = fwd_hit ? wr_data_q : reg_rd_data;

	assign minuend = is_sub_lit ? lit : operand;

	// Carry out of minuend plus inverted accumulator is borrow-not
	nsx_sub_cell #(
		.W(8)
	) nsx_sub_cell_byte_i (
		.minuend    (minuend),
		.subtrahend (acc_q),
		.diff       (diff),
		.borrow_n   (borrow_n)
	);

	// Low nibble only feeds the digit carry
	nsx_sub_cell #(
		.W(4)
	) nsx_sub_cell_nibble_i (
		.minuend    (minuend[3:0]),
		.subtrahend (acc_q[3:0]),
		.diff       (),
		.borrow_n   (nibble_borrow_n)
	);

	always_comb begin
		case (op)
			NSX_OP_NIBBLE_EXCHANGE: begin
				result = {operand[3:0], operand[7:4]};
			end
			NSX_OP_XOR_LITERAL_ACC: begin
				result = acc_q ^ lit;
			end
			NSX_OP_SUB_ACC_FROM_LITERAL,
			NSX_OP_SUB_ACC_FROM_REG: begin
				result = diff;
			end
			default: begin
				result = acc_q;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Accumulator: updated at the taking edge so the next instruction sees it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			acc_q <= `NSX_ACC_RESET;
		end else if (to_acc) begin
			acc_q <= result;
		end
	end

	// Zero flag: xor and subtract; exchange leaves every flag alone
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			zero_q <= `NSX_FLAG_RESET;
		end else if (is_xor_lit || is_sub) begin
			zero_q <= (result == 8'h00);
		end
	end

	// Carry: only subtraction touches it, xor must not
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			carry_q <= `NSX_FLAG_RESET;
		end else if (is_sub) begin
			carry_q <= borrow_n;
		end
	end

	// Digit carry: borrow-not out of the low nibble
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			digit_carry_q <= `NSX_FLAG_RESET;
		end else if (is_sub) begin
			digit_carry_q <= nibble_borrow_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write-back strobe, one cycle per register-destination instruction
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_en_q <= `NSX_WR_EN_RESET;
		end else begin
			wr_en_q <= to_reg;
		end
	end

	// Address and data follow every instruction; only the strobe qualifies them
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_addr_q <= `NSX_WR_ADDR_RESET;
			wr_data_q <= `NSX_WR_DATA_RESET;
		end else begin
			wr_addr_q <= rd_addr;
			wr_data_q <= result;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Every output is a flip-flop
	assign reg_wr_en        = wr_en_q;
	assign reg_wr_addr      = wr_addr_q;
	assign reg_wr_data      = wr_data_q;
	assign acc              = acc_q;
	assign zero_flag        = zero_q;
	assign carry_flag       = carry_q;
	assign digit_carry_flag = digit_carry_q;

endmodule : nsx_alu

////////////////////////////////////////////////////////////////////////////////
// Subtractor with borrow-not
module nsx_sub_cell
	import nsx_pkg::*;
#(
	parameter int W = 8
) (
	// Operands
	input  wire logic [W-1:0] minuend,
	input  wire logic [W-1:0] subtrahend,
	// Result
	output logic      [W-1:0] diff,
	output logic              borrow_n
);

	logic [W:0] sum;

	// Two's complement: minuend plus inverted subtrahend plus one
	assign sum      = {1'h0, minuend} + {1'h0, ~subtrahend} + {{W{1'h0}}, 1'h1};
	assign diff     = sum[W-1:0];
	assign borrow_n = sum[W];

endmodule : nsx_sub_cell

// ---- pkg/nsx_defines.svh ----
// Opcode fields and reset values for the nibble-exchange / xor / subtract datapath
`ifndef NSX_DEFINES_SVH
`define NSX_DEFINES_SVH

`define NSX_OPC_NIBBLE_EXCHANGE 6'h0E
`define NSX_OPC_SUB_ACC_REG     6'h02
`define NSX_OPC_XOR_LIT_ACC     6'h3A
`define NSX_OPC_SUB_LIT_HI      5'h1E
`define NSX_OPC_MSB             13
`define NSX_OPC_LSB             8
`define NSX_DEST_BIT            7
`define NSX_ADDR_MSB            6
`define NSX_LIT_MSB             7
`define NSX_ACC_RESET           8'h00
`define NSX_FLAG_RESET          1'h0
`define NSX_WR_EN_RESET         1'h0
`define NSX_WR_ADDR_RESET       7'h00
`define NSX_WR_DATA_RESET       8'h00

`endif

// ---- pkg/nsx_pkg.sv ----
// Types for the nibble-exchange / xor / subtract datapath
package nsx_pkg;
	typedef enum logic [2:0] {
		NSX_OP_NONE,
		NSX_OP_NIBBLE_EXCHANGE,
		NSX_OP_XOR_LITERAL_ACC,
		NSX_OP_SUB_ACC_FROM_LITERAL,
		NSX_OP_SUB_ACC_FROM_REG
	} nsx_op_t;
endpackage : nsx_pkg

// ---- verif/nsx_alu_assertions.sv ----
// Checker for the execution unit
`timescale 1ns/1ps
module nsx_alu_checker (
	input wire logic core_clk, rst_n, instr_valid, reg_wr_en, zero_flag, carry_flag,
	input wire logic [13:0] instr_word,
	input wire logic [6:0] reg_wr_addr,
	input wire logic [7:0] reg_rd_data, reg_wr_data, acc
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire [5:0] oc = instr_word[13:8];
	wire [7:0] k = instr_word[7:0];
	// Operand the instruction must see: a write-back one cycle old is still in flight
	wire [7:0] opnd = (reg_wr_en && reg_wr_addr == instr_word[6:0]) ? reg_wr_data
		: reg_rd_data;
	sequence s_swap; instr_valid && oc == 6'h0E; endsequence
	sequence s_subl; instr_valid && oc[5:1] == 5'h1E; endsequence
	sequence s_subr; instr_valid && oc == 6'h02; endsequence
	a_swap_to_reg: assert property (s_swap ##0 instr_word[7] |=> reg_wr_en &&
		reg_wr_data == {$past(opnd[3:0]), $past(opnd[7:4])}) else $error("swap reg");
	a_swap_to_acc: assert property (s_swap ##0 !instr_word[7] |=> !reg_wr_en &&
		acc == {$past(opnd[3:0]), $past(opnd[7:4])}) else $error("swap acc");
	a_subreg_carry: assert property (s_subr |=> carry_flag == ($past(opnd) >= $past(acc)))
		else $error("sub reg carry");
	a_swap_keeps_flags: assert property (s_swap |=> $stable(zero_flag) &&
		$stable(carry_flag)) else $error("swap flags");
	a_xor_literal: assert property (instr_valid && oc == 6'h3A |=>
		acc == ($past(acc) ^ $past(k)) && zero_flag == (acc == 8'h00) && $stable(carry_flag))
		else $error("xor");
	a_sub_zero: assert property (s_subl ##0 k == acc |=> carry_flag && zero_flag)
		else $error("sub zero");
	a_sub_negative: assert property (s_subl ##0 k < acc |=> !carry_flag &&
		acc == 8'($past(k) - $past(acc))) else $error("sub neg");
endmodule : nsx_alu_checker
bind nsx_alu nsx_alu_checker nsx_alu_checker_i (.core_clk, .rst_n, .instr_valid, .reg_wr_en,
	.zero_flag, .carry_flag, .instr_word, .reg_wr_addr, .reg_rd_data, .reg_wr_data, .acc);

// ---- verif/nsx_regfile_model.sv ----
// Register file model; a write is seen by reads from the next cycle on
`timescale 1ns/1ps
module nsx_regfile_model (
	input wire logic core_clk, wr_en,
	input wire logic [6:0] rd_addr, wr_addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	logic [7:0] mem_q [128] = '{default: 8'h00};
	assign rd_data = mem_q[rd_addr];
	always @(posedge core_clk) if (wr_en) mem_q[wr_addr] <= wr_data;
endmodule : nsx_regfile_model

// ---- verif/nsx_alu_test.sv ----
// Random self-checking bench for the execution unit
`timescale 1ns/1ps
module nsx_alu_test;
	logic core_clk = 0, rst_n = 0, instr_valid = 0, reg_wr_en, zero_flag, carry_flag, dc;
	logic [13:0] instr_word = 14'h0000;
	logic [7:0] reg_rd_data, reg_wr_data, acc;
	logic [6:0] reg_wr_addr;
	int miscompares = 0, n_tests = 0;
	bit [31:0] s = 32'h314F;
	bit [7:0] m_acc, m_wd, k, v, r, mn, rf [128];
	bit [6:0] a;
	bit m_z, m_c, m_dc, m_we;
	bit [5:0] oc, tbl [8] = '{6'h0E, 6'h0E, 6'h3A, 6'h3C, 6'h3D, 6'h02, 6'h02, 6'h3F};
	nsx_alu nsx_alu_i (.core_clk, .rst_n, .instr_valid, .instr_word, .reg_rd_data, .reg_wr_en,
		.reg_wr_addr, .reg_wr_data, .acc, .zero_flag, .carry_flag, .digit_carry_flag(dc));
	nsx_regfile_model nsx_regfile_model_i (.core_clk, .wr_en(reg_wr_en), .rd_addr(instr_word[6:0]),
		.wr_addr(reg_wr_addr), .wr_data(reg_wr_data), .rd_data(reg_rd_data));
	always #25 core_clk = ~core_clk;
	task chk(string n, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task summarize;
		$display("checks %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	initial begin
		#30000 miscompares++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		#1 rst_n = 1;
		repeat (400) begin
			@(posedge core_clk);
			#1 chk("acc", m_acc, acc);
			chk("zero", {7'h00, m_z}, {7'h00, zero_flag});
			chk("carry", {7'h00, m_c}, {7'h00, carry_flag});
			chk("digit_carry", {7'h00, m_dc}, {7'h00, dc});
			chk("wr_en", {7'h00, m_we}, {7'h00, reg_wr_en});
			if (m_we) chk("wr_data", m_wd, reg_wr_data);
			if (m_we) chk("wr_addr", {1'b0, a}, {1'b0, reg_wr_addr});
			s ^= s << 13;
			s ^= s >> 17;
			s ^= s << 5;
			oc = tbl[s[2:0]];
			k = (s[25:24] == 2'h0) ? m_acc : s[15:8];
			instr_valid = s[30:27] != 4'h0;
			instr_word = {oc, k};
			a = k[6:0];
			v = rf[a];
			m_we = 0;
			if (instr_valid) begin
				mn = (oc == 6'h02) ? v : k;
				r = (oc == 6'h0E) ? {v[3:0], v[7:4]} : mn - m_acc;
				if (oc == 6'h3A) r = m_acc ^ k;
				if (oc != 6'h0E && oc != 6'h3F) m_z = r == 8'h00;
				if (oc == 6'h02 || oc[5:1] == 5'h1E) begin
					m_c = mn >= m_acc;
					m_dc = mn[3:0] >= m_acc[3:0];
				end
				if ((oc == 6'h0E || oc == 6'h02) && k[7]) begin
					m_we = 1;
					m_wd = r;
					rf[a] = r;
				end else if (oc != 6'h3F) m_acc = r;
			end
		end
		summarize();
	end
endmodule : nsx_alu_test
